// file: hdl/fpu_exc_defs.vh
`ifndef FPU_EXC_DEFS_VH
`define FPU_EXC_DEFS_VH
`define CR0_EM_BIT        2
`define CR0_TS_BIT        3
`define VEC_NUMERIC       8'h10
`define VEC_DNA           8'h07
`define VEC_INVALID_OP    8'h06
`define VEC_GEN_PROT      8'h0d
`define IMG_LEGACY_16     10'h05e
`define IMG_LEGACY_32     10'h06c
`define IMG_EXTENDED      10'h200
`define IMG_ALIGN_MASK    32'h0000000f
`define NE_DELAY_CYCLES   4
`define CLASS_WAITING     3'h0
`define CLASS_NOWAIT      3'h1
`define CLASS_WAIT_ONLY   3'h2
`define CLASS_PACKED_INT  3'h3
`define CLASS_NONE        3'h4
`define OP_NONE           3'h0
`define OP_LEGACY_SAVE    3'h1
`define OP_LEGACY_RESTORE 3'h2
`define OP_EXT_SAVE       3'h3
`define OP_EXT_RESTORE    3'h4
`define OP_CLEAR_TS       3'h5
`define OP_TASK_SWITCH    3'h6
`define OP_WRITE_CR0      3'h7
`endif

// file: hdl/fpu_delay_line.v
`timescale 1ns/100ps
`include "fpu_exc_defs.vh"
// fixed delay of a level, models external interrupt path latency
module fpu_delay_line #(
	parameter DEPTH = `NE_DELAY_CYCLES
) (
	// clock and reset
	input  wire             i_clk_sys,
	input  wire             i_resetn,
	// level in and delayed level out
	input  wire             i_level,
	output wire             o_level
);
	reg [DEPTH-1:0] pipe_reg;   // shift stages
	genvar g;
	// each stage copies the one before it; the first stage takes the input level
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : stage
			always @(posedge i_clk_sys or negedge i_resetn) begin
				if (!i_resetn) begin
					pipe_reg[g] <= 1'b0;
				end else if (g == 0) begin
					pipe_reg[g] <= i_level;
				end else begin
					pipe_reg[g] <= pipe_reg[(g == 0) ? 0 : g - 1];
				end
			end
		end
	endgenerate
	assign o_level = pipe_reg[DEPTH-1];
endmodule // fpu_delay_line

// file: hdl/fpu_exception_delivery.v
`timescale 1ns/100ps
`include "fpu_exc_defs.vh"
// decides per issued float insn: fault, error vector or go, and tracks state ops
module fpu_exception_delivery #(
	parameter NE_DELAY = `NE_DELAY_CYCLES
) (
	// clock and reset
	input  wire        i_clk_sys,
	input  wire        i_resetn,
	// instruction issue
	input  wire        i_issue,
	input  wire [2:0]  i_insn_class,
	input  wire [2:0]  i_state_op,
	input  wire        i_op32,
	input  wire [31:0] i_img_addr,
	input  wire        i_cr0_wdata_ts,
	input  wire        i_cr0_wdata_em,
	input  wire        i_native_error_mode,
	// coprocessor side
	input  wire        i_error_n,
	input  wire        i_restore_flags_pending,
	// decision
	output reg         o_go,
	output reg         o_fault,
	output reg  [7:0]  o_vector,
	output reg         o_reinit_unit,
	output reg  [9:0]  o_img_bytes,
	output reg         o_img_extended_layout,
	// status and signalling
	output wire        o_task_switched_flag,
	output wire        o_emulation_flag,
	output wire        o_numeric_pending,
	output reg         o_float_error_out,
	output wire        o_irq,
	// status read and mask write port
	input  wire        i_rd,
	input  wire        i_wr,
	input  wire [1:0]  i_addr,
	input  wire [7:0]  i_wdata,
	output reg  [7:0]  o_rdata
);
	// registers of this block
	localparam [1:0] ADDR_STATUS = 2'h0;     // sticky events
	localparam [1:0] ADDR_MASK   = 2'h1;     // interrupt mask
	localparam [1:0] ADDR_FLAGS  = 2'h2;     // live flags

	// one-hot states of the issue sequencer
	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_ERRP  = 3'b010;      // error pulse after no-wait save
	localparam [2:0] ST_ERRH  = 3'b100;      // hold error through the save

	reg        ts_reg;                        // task-switched flag
	reg        em_reg;                        // emulation flag
	reg        pend_reg;                      // pending numeric exception
	reg [2:0]  state_reg;
	reg [2:0]  state_next;
	reg [3:0]  status_reg;                    // dna, numeric, invop, align
	reg [3:0]  mask_reg;
	reg        err_sync_reg;                  // error line as seen
	reg        err_prev_reg;                  // last cycle's error level, for edge detect
	wire       err_rise;                      // new error event from the coprocessor
	wire       ext_err;                       // delayed error for ne off
	wire       err_seen;
	wire       is_float;
	wire       is_legacy;
	wire       is_ext;
	wire       misalign;
	reg  [3:0] ev;                            // events this cycle

	assign o_task_switched_flag = ts_reg;
	assign o_emulation_flag     = em_reg;
	assign o_numeric_pending    = pend_reg;
	assign o_irq                = |(status_reg & mask_reg);

	// error line registered; the pending level is delayed externally when native mode off
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			err_sync_reg <= 1'b0;
			err_prev_reg <= 1'b0;             // matches idle line, no false edge after reset
		end else begin
			err_sync_reg <= ~i_error_n;
			err_prev_reg <= err_sync_reg;
		end
	end
	// only a new event sets pending; a still-low line must not undo a clearing save
	assign err_rise = err_sync_reg & ~err_prev_reg;

	fpu_delay_line #(.DEPTH(NE_DELAY)) u_delay (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_level   (pend_reg),
		.o_level   (ext_err)
	);
	// native mode sees it internally now; compat mode after path delay
	assign err_seen = i_native_error_mode ? pend_reg : (pend_reg & ext_err);

	assign is_float  = (i_insn_class == `CLASS_WAITING) || (i_insn_class == `CLASS_NOWAIT) ||
	                   (i_insn_class == `CLASS_WAIT_ONLY);
	assign is_legacy = (i_state_op == `OP_LEGACY_SAVE) || (i_state_op == `OP_LEGACY_RESTORE);
	assign is_ext    = (i_state_op == `OP_EXT_SAVE) || (i_state_op == `OP_EXT_RESTORE);
	assign misalign  = |(i_img_addr & `IMG_ALIGN_MASK);

	// issue decision, combinational so the core can act in the same cycle
	always @* begin
		o_go = 1'b0;
		o_fault = 1'b0;
		o_vector = 8'h00;
		ev = 4'h0;
		if (i_issue && i_insn_class == `CLASS_PACKED_INT && em_reg) begin
			o_fault = 1'b1;
			o_vector = `VEC_INVALID_OP;
			ev[2] = 1'b1;
		end else if (i_issue && is_float && i_insn_class != `CLASS_WAIT_ONLY && (ts_reg || em_reg)) begin
			// dna checked ahead of the numeric error
			o_fault = 1'b1;
			o_vector = `VEC_DNA;
			ev[0] = 1'b1;
		end else if (i_issue && i_insn_class != `CLASS_NOWAIT && is_float && err_seen) begin
			o_fault = 1'b1;
			o_vector = `VEC_NUMERIC;
			ev[1] = 1'b1;
		end else if (i_issue && is_ext && misalign) begin
			o_fault = 1'b1;
			o_vector = `VEC_GEN_PROT;
			ev[3] = 1'b1;
		end else if (i_issue) begin
			o_go = 1'b1;
		end
	end

	// image size and layout for the issued state op
	always @* begin
		o_img_bytes = 10'h000;
		o_img_extended_layout = 1'b0;
		o_reinit_unit = 1'b0;
		if (o_go && is_legacy) begin
			o_img_bytes = i_op32 ? `IMG_LEGACY_32 : `IMG_LEGACY_16;
			o_reinit_unit = (i_state_op == `OP_LEGACY_SAVE);
		end else if (o_go && is_ext) begin
			o_img_bytes = `IMG_EXTENDED;
			o_img_extended_layout = 1'b1;
		end
	end

	// control flags
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ts_reg <= 1'b0;
			em_reg <= 1'b0;
		end else if (i_issue && i_state_op == `OP_TASK_SWITCH) begin
			ts_reg <= 1'b1;
		end else if (i_issue && i_state_op == `OP_WRITE_CR0) begin
			ts_reg <= i_cr0_wdata_ts;
			em_reg <= i_cr0_wdata_em;
		end else if (i_issue && i_state_op == `OP_CLEAR_TS) begin
			ts_reg <= 1'b0;
		end
	end

	// pending exception: set by coprocessor, cleared by legacy save, reloaded by restore
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pend_reg <= 1'b0;
		end else if (err_rise) begin
			pend_reg <= 1'b1;                      // set wins over clear
		end else if (o_go && i_state_op == `OP_LEGACY_RESTORE) begin
			pend_reg <= i_restore_flags_pending;
		end else if (o_go && i_state_op == `OP_EXT_RESTORE) begin
			pend_reg <= i_restore_flags_pending;
		end else if (o_go && i_state_op == `OP_LEGACY_SAVE) begin
			pend_reg <= 1'b0;
		end
	end

	// error pulse sequencer for a no-wait save with an error pending
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (o_go && i_state_op == `OP_LEGACY_SAVE && pend_reg) begin
					state_next = ST_ERRP;
				end
			end
			ST_ERRP: begin
				state_next = ST_ERRH;
			end
			ST_ERRH: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// state and error output; error also follows the pending level
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= ST_IDLE;
			o_float_error_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			o_float_error_out <= pend_reg | (state_next != ST_IDLE);
		end
	end

	// sticky status, mask and read port; new events win over read clear
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			status_reg <= 4'h0;
			mask_reg <= 4'h0;
			o_rdata <= 8'h00;
		end else begin
			if (i_rd && i_addr == ADDR_STATUS) begin
				status_reg <= ev;
			end else begin
				status_reg <= status_reg | ev;
			end
			if (i_wr && i_addr == ADDR_MASK) begin
				mask_reg <= i_wdata[3:0];
			end
			if (i_rd && i_addr == ADDR_STATUS) begin
				o_rdata <= {4'h0, status_reg};
			end else if (i_rd && i_addr == ADDR_MASK) begin
				o_rdata <= {4'h0, mask_reg};
			end else if (i_rd && i_addr == ADDR_FLAGS) begin
				o_rdata <= {4'h0, ts_reg, em_reg, pend_reg, o_float_error_out};
			end else begin
				o_rdata <= 8'h00;
			end
		end
	end
endmodule // fpu_exception_delivery

// file: testbench/fpu_coproc_model.sv
`timescale 1ns/100ps
`include "fpu_exc_defs.vh"
// coprocessor error latch seen through its active-low error line
module fpu_coproc_model (
	// clock and reset
	input  wire       i_clk_sys,
	input  wire       i_resetn,
	// exception event and issued op
	input  wire       i_raise,
	input  wire       i_issue,
	input  wire [2:0] i_state_op,
	// error line
	output wire       o_error_n
);
	reg err_reg; // latched unmasked exception
	// held until a clearing save, so a late save still sees it
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			err_reg <= 1'b0;
		else if (i_raise)
			err_reg <= 1'b1;
		else if (i_issue && i_state_op == `OP_LEGACY_SAVE)
			err_reg <= 1'b0;
	end
	assign o_error_n = !err_reg;
endmodule // fpu_coproc_model

// file: testbench/fpu_exc_monitor.sv
`timescale 1ns/100ps
`include "fpu_exc_defs.vh"
// port checks of fault choice, flag updates and image handling
module fpu_exc_monitor (
	input wire        i_clk_sys,
	input wire        i_resetn,
	input wire        i_issue,
	input wire [2:0]  i_insn_class,
	input wire [2:0]  i_state_op,
	input wire        i_op32,
	input wire [31:0] i_img_addr,
	input wire        i_native_error_mode,
	input wire        i_error_n,
	input wire        o_go,
	input wire        o_fault,
	input wire [7:0]  o_vector,
	input wire        o_reinit_unit,
	input wire [9:0]  o_img_bytes,
	input wire        o_img_extended_layout,
	input wire        o_task_switched_flag,
	input wire        o_emulation_flag,
	input wire        o_numeric_pending,
	input wire        o_float_error_out
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	wire ok = !o_task_switched_flag && !o_emulation_flag; // no flag fault
	wire wt = i_issue && i_insn_class == `CLASS_WAITING; // waiting insn
	wire sv = i_issue && o_go && i_state_op == `OP_LEGACY_SAVE; // clearing save
	// save with a pending error, then the pulse
	sequence s_save_pend;
		sv && o_numeric_pending;
	endsequence
	a_ts_dna_fault: assert property (wt && o_task_switched_flag |-> o_fault && o_vector == `VEC_DNA)
		else $error("ts flag did not fault");
	a_em_invalid_op: assert property (i_issue && i_insn_class == `CLASS_PACKED_INT && o_emulation_flag
		|-> o_fault && o_vector == `VEC_INVALID_OP) else $error("packed op not refused");
	a_pending_vector: assert property (wt && ok && i_native_error_mode && o_numeric_pending |-> !o_go && o_vector == `VEC_NUMERIC)
		else $error("pending error not taken");
	a_nowait_keeps: assert property (i_issue && i_insn_class == `CLASS_NOWAIT && ok && i_state_op == `OP_NONE
		&& o_numeric_pending |-> o_go && !o_fault ##1 o_numeric_pending) else $error("nowait disturbed");
	a_clear_ts: assert property (i_issue && i_state_op == `OP_CLEAR_TS |=> !o_task_switched_flag)
		else $error("ts flag not cleared");
	a_switch_sets: assert property (i_issue && i_state_op == `OP_TASK_SWITCH |=> o_task_switched_flag)
		else $error("ts flag not set");
	a_save_pulse: assert property (s_save_pend |-> ##2 o_float_error_out) else $error("no error pulse");
	a_legacy_image: assert property (sv |-> o_reinit_unit && !o_img_extended_layout
		&& o_img_bytes == (i_op32 ? `IMG_LEGACY_32 : `IMG_LEGACY_16)) else $error("bad legacy image");
	a_ext_image: assert property (i_issue && o_go && i_state_op == `OP_EXT_SAVE |-> !o_reinit_unit
		&& o_img_extended_layout && o_img_bytes == `IMG_EXTENDED) else $error("bad ext image");
	a_ext_misalign: assert property (i_issue && i_state_op == `OP_EXT_RESTORE && (i_img_addr & `IMG_ALIGN_MASK) != 0
		|-> o_fault && o_vector == `VEC_GEN_PROT) else $error("misaligned image taken");
	a_error_pends: assert property (i_native_error_mode && $fell(i_error_n) |-> ##[1:3] o_numeric_pending)
		else $error("error not recorded");
endmodule // fpu_exc_monitor

// file: testbench/fpu_exception_delivery_test.sv
`timescale 1ns/100ps
`include "fpu_exc_defs.vh"
// directed runs through flag faults, pending errors and state images
module fpu_exception_delivery_test;
	reg        i_clk_sys = 0, i_resetn = 0, i_issue = 0, i_op32 = 0, i_rd = 0, i_wr = 0;
	reg  [2:0] i_insn_class = `CLASS_NONE, i_state_op = `OP_NONE;
	reg [31:0] i_img_addr = 0;
	reg        i_cr0_wdata_ts = 0, i_cr0_wdata_em = 0, i_restore_flags_pending = 0, raise = 0;
	reg        i_native_error_mode = 1; // native mode first; delayed mode is run in the last test
	reg  [1:0] i_addr = 0;
	reg  [7:0] i_wdata = 0;
	wire       i_error_n, o_go, o_fault, o_reinit_unit, o_img_extended_layout, o_irq;
	wire       o_task_switched_flag, o_emulation_flag, o_numeric_pending, o_float_error_out;
	wire [7:0] o_vector, o_rdata;
	wire [9:0] o_img_bytes;
	integer    miscompares = 0, samples_checked = 0;
	fpu_exception_delivery #(.NE_DELAY(2)) dut (.*);
	fpu_coproc_model cop (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_raise(raise),
		.i_issue(i_issue), .i_state_op(i_state_op), .o_error_n(i_error_n));
	initial forever #50 i_clk_sys = ~i_clk_sys;
	// one comparison, counted
	task chk(input [8*8-1:0] nm, input [9:0] exp, input [9:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one issue cycle; vector ff skips the decision check
	task iss(input [2:0] c, input [2:0] op, input [31:0] a, input g, input [7:0] v, input [9:0] b);
		@(posedge i_clk_sys);
		{i_issue, i_insn_class, i_state_op, i_img_addr} <= {1'b1, c, op, a};
		#10 if (v != 8'hff) begin
			chk("go", g, o_go);
			chk("fault", !g, o_fault);
			if (!g) chk("vector", v, o_vector);
		end
		if (g && b != 0) chk("bytes", b, o_img_bytes);
		@(posedge i_clk_sys);
		{i_issue, i_insn_class, i_state_op} <= {1'b0, `CLASS_NONE, `OP_NONE};
	endtask
	task wr(input [1:0] a, input [7:0] d);
		@(posedge i_clk_sys);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_clk_sys);
		i_wr <= 0;
	endtask
	task rd(input [1:0] a, input [7:0] e);
		@(posedge i_clk_sys);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_clk_sys);
		i_rd <= 0;
		#10 chk("rdata", e, o_rdata);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hang guard, far beyond the eighty or so cycles of the run
	initial begin
		#200000 miscompares++;
		end_of_test;
	end
	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_resetn <= 1;
		rd(2'h2, 8'h00);
		wr(2'h1, 8'h0f);
		rd(2'h1, 8'h0f);
		$display("test reset_regs done");
		iss(`CLASS_NONE, `OP_TASK_SWITCH, 0, 0, 8'hff, 0);
		iss(`CLASS_WAITING, `OP_NONE, 0, 0, `VEC_DNA, 0);
		#10 chk("irq", 1, o_irq);
		rd(2'h0, 8'h01);
		chk("irq", 0, o_irq);
		iss(`CLASS_NONE, `OP_CLEAR_TS, 0, 0, 8'hff, 0);
		iss(`CLASS_WAITING, `OP_NONE, 0, 1, 0, 0);
		i_cr0_wdata_em <= 1;
		iss(`CLASS_NONE, `OP_WRITE_CR0, 0, 0, 8'hff, 0);
		iss(`CLASS_PACKED_INT, `OP_NONE, 0, 0, `VEC_INVALID_OP, 0);
		iss(`CLASS_NOWAIT, `OP_NONE, 0, 0, `VEC_DNA, 0);
		i_cr0_wdata_em <= 0;
		iss(`CLASS_NONE, `OP_WRITE_CR0, 0, 0, 8'hff, 0);
		rd(2'h0, 8'h05);
		$display("test flag_faults done");
		raise <= 1;
		@(posedge i_clk_sys) raise <= 0;
		repeat (4) @(posedge i_clk_sys);
		iss(`CLASS_NOWAIT, `OP_NONE, 0, 1, 0, 0);
		#10 chk("pending", 1, o_numeric_pending);
		iss(`CLASS_NONE, `OP_TASK_SWITCH, 0, 0, 8'hff, 0);
		iss(`CLASS_WAITING, `OP_NONE, 0, 0, `VEC_DNA, 0);
		iss(`CLASS_NONE, `OP_CLEAR_TS, 0, 0, 8'hff, 0);
		iss(`CLASS_WAITING, `OP_NONE, 0, 0, `VEC_NUMERIC, 0);
		rd(2'h0, 8'h03);
		iss(`CLASS_NOWAIT, `OP_LEGACY_SAVE, 0, 1, 0, `IMG_LEGACY_16);
		repeat (3) @(posedge i_clk_sys);
		#10 chk("pending", 0, o_numeric_pending);
		$display("test error_path done");
		{i_restore_flags_pending, i_op32} <= 2'b11;
		iss(`CLASS_NOWAIT, `OP_LEGACY_RESTORE, 0, 1, 0, `IMG_LEGACY_32);
		i_restore_flags_pending <= 0;
		iss(`CLASS_WAITING, `OP_NONE, 0, 0, `VEC_NUMERIC, 0);
		iss(`CLASS_NOWAIT, `OP_LEGACY_SAVE, 0, 1, 0, `IMG_LEGACY_32);
		i_op32 <= 0;
		iss(`CLASS_NONE, `OP_EXT_SAVE, 32'h100, 1, 0, `IMG_EXTENDED);
		iss(`CLASS_NONE, `OP_EXT_RESTORE, 32'h108, 0, `VEC_GEN_PROT, 0);
		rd(2'h0, 8'h0a);
		rd(2'h3, 8'h00);
		$display("test images done");
		// native mode off: error reaches the core after the path delay
		i_native_error_mode <= 0;
		raise <= 1;
		@(posedge i_clk_sys) raise <= 0;
		repeat (8) @(posedge i_clk_sys);
		#10 chk("pending", 1, o_numeric_pending);
		iss(`CLASS_WAITING, `OP_NONE, 0, 0, `VEC_NUMERIC, 0);
		iss(`CLASS_NOWAIT, `OP_LEGACY_SAVE, 0, 1, 0, `IMG_LEGACY_16);
		repeat (3) @(posedge i_clk_sys);
		#10 chk("pending", 0, o_numeric_pending);
		$display("test delayed_mode done");
		end_of_test;
	end
endmodule // fpu_exception_delivery_test
bind fpu_exception_delivery fpu_exc_monitor mon (.*);
